// File: pmc_map.vh
// Constants for the per-port management and mode control block
`ifndef PMC_MAP_VH
`define PMC_MAP_VH
`define PMC_NUM_PORTS 8
`define PMC_PHYAD_W 5
`define PMC_REGAD_W 5
`define PMC_OP_WRITE 2'b01
`define PMC_OP_READ 2'b10
`define PMC_PREAMBLE_BITS 32
`define PMC_REG_CTRL 5'h00
`define PMC_REG_STAT 5'h01
`define PMC_REG_MODE 5'h10
`define PMC_REG_IRQ_EN 5'h12
`define PMC_REG_IRQ_STAT 5'h13
`define PMC_MODE_FX_BIT 0
`define PMC_IRQ_EN_BIT 1
`define PMC_CTRL_ANEG_BIT 12
`define PMC_CTRL_SPEED_BIT 13
`define PMC_CTRL_DUPLEX_BIT 8
`define PMC_CTRL_RESET 16'h3100
`define PMC_MDC_MAX_HZ 8000000
`define PMC_CLK_HZ 250000000
`endif

// File: pmc_port_regs.v
// Per-port register storage with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "pmc_map.vh"
module pmc_port_regs #(
  parameter PORTS = `PMC_NUM_PORTS,
  parameter AW = 3
) (
  input wire clk_sys,
  input wire srst,
  input wire [AW-1:0] rd_port,
  output reg [15:0] ctrl_rd_q,
  input wire wr_en,
  input wire [AW-1:0] wr_port,
  input wire [15:0] wr_data,
  input wire load_en,
  input wire [PORTS*16-1:0] load_data
);
  reg [15:0] mem_q [0:PORTS-1];
  integer i;

  // Strap load wins over a serial write in the same cycle
  always @(posedge clk_sys)
  begin
    if (srst || load_en)
    begin
      for (i = 0; i < PORTS; i = i + 1)
        mem_q[i] <= srst ? `PMC_CTRL_RESET : load_data[i*16 +: 16];
    end
    else if (wr_en)
      mem_q[wr_port] <= wr_data;
  end

  // Read data out of a register
  always @(posedge clk_sys)
  begin
    if (srst)
      ctrl_rd_q <= 16'h0000;
    else
      ctrl_rd_q <= mem_q[rd_port];
  end
endmodule // pmc_port_regs
`default_nettype wire

// File: pmc_mgmt.v
// Management serial slave, strap load, media select and status interrupt
// What this block does
// - Management over one bidirectional data line, management clock.
// - Open-drain interrupt low on status change when enabled.
// - Disable input high during start or header blocks that frame's serial read or write.
// - Hardware pins only load defaults at reset.
// - After reset, serial channel owns bits; pins ignored.
// - Signal-detect high sets fiber mode bit to one.
// - Signal-detect low clears fiber mode bit, twisted pair.
// - Speed, duplex, auto-negotiation selectable per port by pins.
// - Standard register set, register and bit numbering.
// - Independent mode, detect and registers per port 0-7.
`timescale 1ns/1ns
`default_nettype none
`include "pmc_map.vh"
module pmc_mgmt #(
  parameter PORTS = `PMC_NUM_PORTS,
  parameter [4:0] BASE_PHYAD = 5'h00
) (
  input wire clk_sys,
  input wire srst,
  input wire mdc,
  input wire mdio_i,
  output reg mdio_o,
  output reg mdio_oe,
  output wire mgmt_status_irq_n,
  output reg mgmt_status_irq_oe,
  input wire mgmt_port_disable,
  input wire [PORTS-1:0] signal_detect_tp_select,
  input wire [PORTS-1:0] pin_aneg_en,
  input wire [PORTS-1:0] pin_speed_100,
  input wire [PORTS-1:0] pin_full_duplex,
  input wire [PORTS-1:0] link_up,
  output reg [PORTS-1:0] fiber_mode_q,
  output reg [PORTS-1:0] aneg_en_q,
  output reg [PORTS-1:0] speed_100_q,
  output reg [PORTS-1:0] full_duplex_q
);
  localparam ST_IDLE = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_HDR = 3'd2;
  localparam ST_TA = 3'd3;
  localparam ST_WDATA = 3'd4;
  localparam ST_RDATA = 3'd5;

  // Two flops on every outside input except srst
  reg [1:0] mdc_s, mdio_s, dis_s;
  reg [PORTS-1:0] sd_a, sd_b, ln_a, ln_b;
  reg [3*PORTS-1:0] strap_a, strap_b;
  reg mdc_prev_q;
  always @(posedge clk_sys)
  begin
    mdc_s <= {mdc_s[0], mdc};
    mdio_s <= {mdio_s[0], mdio_i};
    dis_s <= {dis_s[0], mgmt_port_disable};
    sd_a <= signal_detect_tp_select;
    sd_b <= sd_a;
    ln_a <= link_up;
    ln_b <= ln_a;
    strap_a <= {pin_aneg_en, pin_speed_100, pin_full_duplex}; // Read at load
    strap_b <= strap_a;
    mdc_prev_q <= mdc_s[1];
  end
  wire mdc_rise = mdc_s[1] & ~mdc_prev_q;
  wire mdc_fall = ~mdc_s[1] & mdc_prev_q;
  wire bit_in = mdio_s[1];

  function [15:0] pack_ctrl;
    input aneg;
    input spd;
    input dup;
    begin
      pack_ctrl = 16'h0000;
      pack_ctrl[`PMC_CTRL_ANEG_BIT] = aneg;
      pack_ctrl[`PMC_CTRL_SPEED_BIT] = spd;
      pack_ctrl[`PMC_CTRL_DUPLEX_BIT] = dup;
    end
  endfunction

  // Strap pins captured one cycle after reset release only
  reg strap_pend_q;
  reg load_q;
  reg [PORTS*16-1:0] load_data;
  integer p;
  always @*
  begin
    load_data = {PORTS*16{1'b0}};
    for (p = 0; p < PORTS; p = p + 1)
      load_data[p*16 +: 16] = pack_ctrl(strap_b[2*PORTS+p],
        strap_b[PORTS+p], strap_b[p]);
  end
  always @(posedge clk_sys)
  begin
    strap_pend_q <= srst;
    load_q <= !srst && strap_pend_q;
  end

  // Frame decoder
  reg [2:0] st_q;
  reg [5:0] cnt_q;
  reg [1:0] op_q;
  reg [9:0] hdr_q;
  reg [15:0] sh_q;
  reg ign_q;
  reg [15:0] rd_word;
  reg [15:0] irq_en_q [0:PORTS-1];
  reg [PORTS-1:0] irq_stat_q;
  wire [4:0] phyad = hdr_q[9:5];
  wire [4:0] regad = hdr_q[4:0];
  wire [4:0] port_off = phyad - BASE_PHYAD;
  wire port_hit = (port_off < PORTS);
  wire [2:0] port_idx = port_off[2:0];
  wire [15:0] ctrl_rd;
  wire wr_fire = (st_q == ST_WDATA) && mdc_rise && (cnt_q == 6'd15) &&
    !ign_q && port_hit;
  wire [15:0] wr_word = {sh_q[14:0], bit_in};
  wire ctrl_wr = wr_fire && (regad == `PMC_REG_CTRL) && !load_q;

  pmc_port_regs #(.PORTS(PORTS), .AW(3)) u_regs (
    .clk_sys(clk_sys),
    .srst(srst),
    .rd_port(port_idx),
    .ctrl_rd_q(ctrl_rd),
    .wr_en(ctrl_wr),
    .wr_port(port_idx),
    .wr_data(wr_word),
    .load_en(load_q),
    .load_data(load_data)
  );

  // Read mux of the standard register numbers
  always @*
  begin
    case (regad)
      `PMC_REG_CTRL: rd_word = ctrl_rd;
      `PMC_REG_STAT: rd_word = {13'h0000, ln_b[port_idx], 2'b00};
      `PMC_REG_MODE: rd_word = {15'h0000, fiber_mode_q[port_idx]};
      `PMC_REG_IRQ_EN: rd_word = irq_en_q[port_idx];
      `PMC_REG_IRQ_STAT: rd_word = {15'h0000, irq_stat_q[port_idx]};
      default: rd_word = 16'h0000;
    endcase
  end

  // Serial frame sequencer; sampled on rising, driven after falling edge
  always @(posedge clk_sys)
  begin
    if (srst)
    begin
      st_q <= ST_IDLE;
      cnt_q <= 6'd0;
      op_q <= 2'b00;
      hdr_q <= 10'h000;
      sh_q <= 16'h0000;
      ign_q <= 1'b0;
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end
    else
    begin
      if (mdc_rise)
      begin
        case (st_q)
          ST_IDLE:
          begin
            if (bit_in)
              cnt_q <= (cnt_q == 6'd32) ? cnt_q : cnt_q + 6'd1;
            else if (cnt_q == `PMC_PREAMBLE_BITS)
              st_q <= ST_START;
            else
              cnt_q <= 6'd0;
          end
          ST_START:
          begin
            st_q <= bit_in ? ST_HDR : ST_IDLE;
            cnt_q <= 6'd0;
            ign_q <= dis_s[1];
          end
          ST_HDR:
          begin
            if (cnt_q < 6'd2)
              op_q <= {op_q[0], bit_in};
            else
              hdr_q <= {hdr_q[8:0], bit_in};
            if (dis_s[1])
              ign_q <= 1'b1;
            if (cnt_q == 6'd11)
            begin
              st_q <= ST_TA;
              cnt_q <= 6'd0;
            end
            else
              cnt_q <= cnt_q + 6'd1;
          end
          ST_TA:
          begin
            if (cnt_q == 6'd1)
            begin
              st_q <= (op_q == `PMC_OP_READ) ? ST_RDATA : ST_WDATA;
              cnt_q <= 6'd0;
              sh_q <= rd_word;
            end
            else
              cnt_q <= cnt_q + 6'd1;
          end
          ST_WDATA, ST_RDATA:
          begin
            sh_q <= (st_q == ST_WDATA) ? {sh_q[14:0], bit_in}
              : {sh_q[14:0], 1'b0};
            if (cnt_q == 6'd15)
            begin
              st_q <= ST_IDLE;
              cnt_q <= 6'd0;
            end
            else
              cnt_q <= cnt_q + 6'd1;
          end
          default: st_q <= ST_IDLE;
        endcase
      end
      // Drive read data after falling edge; disabled frames stay off bus
      if (mdc_fall)
      begin
        mdio_oe <= (st_q == ST_RDATA || (st_q == ST_TA && cnt_q == 6'd1))
          && !ign_q && port_hit && op_q == `PMC_OP_READ;
        mdio_o <= (st_q == ST_RDATA) ? sh_q[15] : 1'b0;
      end
    end
  end

  // Fiber mode follows the select pin only
  always @(posedge clk_sys)
    fiber_mode_q <= srst ? {PORTS{1'b0}} : sd_b;

  // Operating mode out of the control register copy
  integer k;
  always @(posedge clk_sys)
  begin
    for (k = 0; k < PORTS; k = k + 1)
    begin
      if (srst)
      begin
        {aneg_en_q[k], speed_100_q[k], full_duplex_q[k]} <= 3'b000;
        irq_en_q[k] <= 16'h0000;
      end
      else if (load_q)
        {aneg_en_q[k], speed_100_q[k], full_duplex_q[k]} <= {
          strap_b[2*PORTS+k], strap_b[PORTS+k], strap_b[k]};
      else if (wr_fire && port_idx == k && regad == `PMC_REG_CTRL)
        {aneg_en_q[k], speed_100_q[k], full_duplex_q[k]} <= {
          wr_word[`PMC_CTRL_ANEG_BIT], wr_word[`PMC_CTRL_SPEED_BIT],
          wr_word[`PMC_CTRL_DUPLEX_BIT]};
      else if (wr_fire && port_idx == k && regad == `PMC_REG_IRQ_EN)
        irq_en_q[k] <= wr_word;
    end
  end

  // Sticky change flags; a new change beats the read that clears it
  reg [PORTS-1:0] ln_prev_q, fx_prev_q;
  wire rd_clr = (st_q == ST_TA) && mdc_rise && (cnt_q == 6'd1) &&
    (op_q == `PMC_OP_READ) && (regad == `PMC_REG_IRQ_STAT) &&
    !ign_q && port_hit;
  integer j;
  always @(posedge clk_sys)
  begin
    ln_prev_q <= ln_b;
    fx_prev_q <= fiber_mode_q;
    for (j = 0; j < PORTS; j = j + 1)
    begin
      if (srst)
        irq_stat_q[j] <= 1'b0;
      else if ((ln_b[j] != ln_prev_q[j]) || (fiber_mode_q[j] != fx_prev_q[j]))
        irq_stat_q[j] <= 1'b1;
      else if (rd_clr && port_idx == j)
        irq_stat_q[j] <= 1'b0;
    end
  end

  // Open drain: only ever pulls low, gated by each port's enable bit
  reg any_irq;
  integer m;
  always @*
  begin
    any_irq = 1'b0;
    for (m = 0; m < PORTS; m = m + 1)
      any_irq = any_irq | (irq_stat_q[m] & irq_en_q[m][`PMC_IRQ_EN_BIT]);
  end
  always @(posedge clk_sys)
    mgmt_status_irq_oe <= !srst && any_irq;
  assign mgmt_status_irq_n = 1'b0;
endmodule // pmc_mgmt
`default_nettype wire

// File: pmc_mgmt_properties.sv
// Port-level assertions for the management and mode control block
`timescale 1ns/1ns
`default_nettype none
module pmc_mgmt_props #(parameter PORTS = 8) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic mdc,
  input wire logic mdio_oe,
  input wire logic mgmt_status_irq_n,
  input wire logic mgmt_status_irq_oe,
  input wire logic mgmt_port_disable,
  input wire logic [PORTS-1:0] signal_detect_tp_select,
  input wire logic [PORTS-1:0] pin_aneg_en,
  input wire logic [PORTS-1:0] pin_speed_100,
  input wire logic [PORTS-1:0] pin_full_duplex,
  input wire logic [PORTS-1:0] fiber_mode_q,
  input wire logic [PORTS-1:0] aneg_en_q,
  input wire logic [PORTS-1:0] speed_100_q,
  input wire logic [PORTS-1:0] full_duplex_q
);
  logic [9:0] dis_q;
  logic [9:0] oe_q;
  logic [2:0] up_q;
  wire [3*PORTS-1:0] mode = {aneg_en_q, speed_100_q, full_duplex_q};
  // Saturating counts; disable count outlasts any read already under way
  always @(posedge clk_sys)
  begin
    dis_q <= (srst | ~mgmt_port_disable) ? 10'h0 : dis_q + {9'h0, ~&dis_q};
    oe_q <= (srst | ~mdio_oe) ? 10'h0 : oe_q + {9'h0, ~&oe_q};
    up_q <= srst ? 3'h0 : up_q + {2'h0, ~&up_q};
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_media; $stable(signal_detect_tp_select) [*8] |->
    fiber_mode_q == signal_detect_tp_select; endproperty
  a_media: assert property (p_media)
    else $error("media bits do not follow pins");
  property p_odrain; mgmt_status_irq_oe |-> !mgmt_status_irq_n; endproperty
  a_odrain: assert property (p_odrain)
    else $error("interrupt pin not pulled low");
  property p_dis_drive; dis_q == 10'h3ff |-> !mdio_oe; endproperty
  a_dis_drive: assert property (p_dis_drive)
    else $error("data line driven while disabled");
  property p_dis_write; dis_q == 10'h3ff |-> $stable(mode); endproperty
  a_dis_write: assert property (p_dis_write)
    else $error("mode changed while disabled");
  property p_strap; $fell(srst) |-> ##[2:4]
    mode == {pin_aneg_en, pin_speed_100, pin_full_duplex}; endproperty
  a_strap: assert property (p_strap)
    else $error("strap values not loaded");
  // Later changes only from a frame, so the clock was high just before
  property p_pins; up_q == 3'h7 && $changed(mode) |-> $past(mdc, 3);
  endproperty
  a_pins: assert property (p_pins)
    else $error("mode changed outside a frame");
  property p_edge; $rose(mdio_oe) |-> !mdc && !$past(mdc, 2); endproperty
  a_edge: assert property (p_edge)
    else $error("drive began off the falling edge");
  property p_len; mdio_oe |-> oe_q < 10'h21c; endproperty
  a_len: assert property (p_len)
    else $error("drive longer than turnaround and data");
endmodule // pmc_mgmt_props
bind pmc_mgmt pmc_mgmt_props #(.PORTS(PORTS)) u_props (.clk_sys(clk_sys),
  .srst(srst), .mdc(mdc), .mdio_oe(mdio_oe),
  .mgmt_status_irq_n(mgmt_status_irq_n),
  .mgmt_status_irq_oe(mgmt_status_irq_oe),
  .mgmt_port_disable(mgmt_port_disable),
  .signal_detect_tp_select(signal_detect_tp_select),
  .pin_aneg_en(pin_aneg_en), .pin_speed_100(pin_speed_100),
  .pin_full_duplex(pin_full_duplex), .fiber_mode_q(fiber_mode_q),
  .aneg_en_q(aneg_en_q), .speed_100_q(speed_100_q),
  .full_duplex_q(full_duplex_q));
`default_nettype wire

// File: pmc_station.sv
// Management station model on the serial management port
`timescale 1ns/1ns
`default_nettype none
module pmc_station (
  output var logic mdc,
  output logic mdio_line,
  input wire logic mdio_o,
  input wire logic mdio_oe
);
  logic dr_en = 1'b0;
  logic dr_d = 1'b0;
  initial mdc = 1'b0;
  // Pull-up holds the line high when nobody drives
  assign mdio_line = mdio_oe ? mdio_o : (dr_en ? dr_d : 1'b1);
  // One frame; clock stands low between frames
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
    input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    f = {32'hffff_ffff, 2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 63; i >= 0; i--)
    begin
      dr_en = !(op == 2'b10 && i < 18);
      dr_d = f[i];
      #62 mdc = 1'b1;
      rd = {rd[14:0], mdio_line};
      #63 mdc = 1'b0;
    end
    dr_en = 1'b0;
  endtask
endmodule // pmc_station
`default_nettype wire

// File: tb_pmc_mgmt.sv
// Self-checking bench for the management and mode control block
`timescale 1ns/1ns
`default_nettype none
module tb_pmc_mgmt;
  localparam int NP = 8;
  logic clk_sys, srst, dis, mdc, line;
  logic [NP-1:0] sd, p_an, p_sp, p_fd, link;
  wire mdo, oe, irq_n, irq_oe;
  wire [NP-1:0] fib, an, sp, fd;
  logic [15:0] rd;
  int failures = 0;
  int samples_checked = 0;
  int exp_ctl [NP];
  int p, k, q;
  pmc_mgmt uut (.clk_sys(clk_sys), .srst(srst), .mdc(mdc), .mdio_i(line),
    .mdio_o(mdo), .mdio_oe(oe), .mgmt_status_irq_n(irq_n),
    .mgmt_status_irq_oe(irq_oe), .mgmt_port_disable(dis),
    .signal_detect_tp_select(sd), .pin_aneg_en(p_an),
    .pin_speed_100(p_sp), .pin_full_duplex(p_fd), .link_up(link),
    .fiber_mode_q(fib), .aneg_en_q(an), .speed_100_q(sp),
    .full_duplex_q(fd));
  pmc_station stn (.mdc(mdc), .mdio_line(line), .mdio_o(mdo),
    .mdio_oe(oe));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Inputs change one step after the rising edge
  task automatic at1(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cmp_port(int i);
    check("mode", {2'h0, sp[i], an[i], 3'h0, fd[i], 8'h00},
      exp_ctl[i][15:0]);
  endtask
  task automatic cmp_all;
    for (int i = 0; i < NP; i++) cmp_port(i);
  endtask
  initial
  begin
    srst = 1'b1;
    dis = 1'b0;
    link = '0;
    k = $urandom(85);
    {p_an, p_sp, p_fd, sd} = $urandom;
    p_an = p_an & ~sd;
    at1(3);
    srst = 1'b0;
    at1(6);
    for (p = 0; p < NP; p++)
      exp_ctl[p] = (p_sp[p] << 13) | (p_an[p] << 12) | (p_fd[p] << 8);
    cmp_all();
    {p_an, p_sp, p_fd} = ~{p_an, p_sp, p_fd};
    at1(20);
    cmp_all();
    // Each port written and read back with random mode bits
    for (p = 0; p < NP; p++)
    begin
      k = $urandom & 32'h3100 & ~{19'h0, sd[p], 12'h000};
      stn.xfer(2'b01, p[4:0], 5'h00, k[15:0], rd);
      exp_ctl[p] = k;
      at1(8);
      cmp_port(p);
      stn.xfer(2'b10, p[4:0], 5'h00, 16'h0000, rd);
      check("ctrl read", rd & 16'h3100, k[15:0]);
      stn.xfer(2'b10, p[4:0], 5'h10, 16'h0000, rd);
      check("media read", {15'h0, rd[0]}, {15'h0, sd[p]});
    end
    // Fiber only where auto-negotiation is off; no link, pin stays high
    at1(1);
    for (p = 0; p < NP; p++)
      sd[p] = ~sd[p] & ~exp_ctl[p][12];
    at1(12);
    check("fiber", {8'h00, fib}, {8'h00, sd});
    // Disabled: write lost, read finds only the pull-up
    dis = 1'b1;
    stn.xfer(2'b01, 5'h00, 5'h00, exp_ctl[0][15:0] ^ 16'h2100, rd);
    stn.xfer(2'b10, 5'h00, 5'h00, 16'h0000, rd);
    check("disabled read", rd, 16'hffff);
    at1(1);
    dis = 1'b0;
    stn.xfer(2'b01, 5'h08, 5'h00, 16'h2100, rd);
    at1(8);
    cmp_all();
    // Status change with the enable clear, then set
    q = $urandom % NP;
    link[q] = 1'b1;
    at1(20);
    check("irq masked", {14'h0, irq_n, irq_oe}, 16'h0000);
    stn.xfer(2'b10, q[4:0], 5'h13, 16'h0000, rd);
    check("change flag", {15'h0, rd[0]}, 16'h0001);
    stn.xfer(2'b01, q[4:0], 5'h12, 16'h0002, rd);
    at1(1);
    link[q] = 1'b0;
    for (p = 0; p < 100 && irq_oe !== 1'b1; p++) at1(1);
    if (p == 100)
    begin
      failures++;
      finish_test();
    end
    check("irq raised", {14'h0, irq_n, irq_oe}, 16'h0001);
    stn.xfer(2'b10, q[4:0], 5'h13, 16'h0000, rd);
    at1(10);
    check("irq cleared", {15'h0, irq_oe}, 16'h0000);
    finish_test();
  end
endmodule // tb_pmc_mgmt
`default_nettype wire
